// ===== design/pst_defines.vh
`ifndef PST_DEFINES_VH
`define PST_DEFINES_VH

// ************************************************************
// Register indices; the byte address is four times the index.
// ************************************************************
`define PST_IDX_LOW_B0   9'h002
`define PST_IDX_LOW_B1   9'h082
`define PST_IDX_LOW_B2   9'h102
`define PST_IDX_LOW_B3   9'h182
`define PST_IDX_LATH_B0  9'h00A
`define PST_IDX_LATH_B1  9'h08A
`define PST_IDX_LATH_B2  9'h10A
`define PST_IDX_LATH_B3  9'h18A
`define PST_IDX_VIEW     9'h10C
`define PST_IDX_TDATA    9'h18C
`define PST_IDX_PTR_LO   9'h185
`define PST_IDX_PTR_HI   9'h186

// ************************************************************
// Decoded register identities.
// ************************************************************
`define PST_RID_NONE     3'h0
`define PST_RID_LOW      3'h1
`define PST_RID_LATH     3'h2
`define PST_RID_VIEW     3'h3
`define PST_RID_TDATA    3'h4
`define PST_RID_PTR_LO   3'h5
`define PST_RID_PTR_HI   3'h6

// ************************************************************
// Reset values, vectors and special data values.
// ************************************************************
`define PST_RESET_VEC    11'h000
`define PST_INT_VEC      11'h004
`define PST_BYTE_RST     8'h00
`define PST_SEL_KEY      8'h1C
`define PST_TDATA_LOW    8'h01
`define PST_TDATA_HIGH   8'h02

// ************************************************************
// Operation codes from the instruction decoder.
// ************************************************************
`define PST_OP_NEXT      4'h0
`define PST_OP_GOTO      4'h1
`define PST_OP_CALL      4'h2
`define PST_OP_RETURN    4'h3
`define PST_OP_RETLIT    4'h4
`define PST_OP_INT       4'h5
`define PST_OP_TRL       4'h6
`define PST_OP_TRH       4'h7
`define PST_OP_LOWWR     4'h8

`endif

// ===== design/pst_stack.v
`timescale 1ns/100ps
module pst_stack #(
   parameter DEPTH = 8,
   parameter WIDTH = 12,
   parameter PTR_W = 3
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             push,
   input  wire             pop,
   input  wire [WIDTH-1:0] push_data,
   output wire [WIDTH-1:0] top
);

   // ************************************************************
   // Circular storage; a ninth push silently replaces the oldest.
   // ************************************************************
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [PTR_W-1:0] sp;

   wire [PTR_W-1:0] sp_dec = sp - {{(PTR_W-1){1'b0}}, 1'b1};

   // Popping an empty stack returns whatever the slot holds.
   assign top = mem[sp_dec];

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sp <= {PTR_W{1'b0}};
      end else if (push) begin
         sp <= sp + {{(PTR_W-1){1'b0}}, 1'b1};
      end else if (pop) begin
         sp <= sp_dec;
      end
   end

   // Storage has no reset so it maps onto plain memory.
   always @(posedge clk) begin
      if (push) begin
         mem[sp] <= push_data;
      end
   end

endmodule // pst_stack

// ===== design/pst_core.v
// Operation
// - Program counter is 11 bits, addressing 2K words of 16 bits.
// - Counter advances by one per executed instruction unless replaced.
// - Reset loads address 000h; interrupt entry loads address 004h.
// - Call and goto take all 11 target bits from the instruction.
// - All return forms reload the counter from the stack top.
// - Low-byte register reads and writes counter bits 7..0 in all banks.
// - High view reads counter bits 10..8; writing never loads the counter.
// - Writing 1Ch to the high view sets the select flag, else clears it.
// - Any reset clears the select flag.
// - Flag clear: low-byte write also loads bits 10..8 from the latch.
// - Flag set: low-byte write changes only bits 7..0.
// - Return stack holds eight entries of 12 bits.
// - Long call and interrupt push; returns pop last in, first out.
// - Table reads fetch one byte of the word at the pointer into W and data register.
// - Writing 01h or 02h to the table data register starts a read.
// - After a triggered read, the table data register returns the fetched byte.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
`include "pst_defines.vh"
module pst_core #(
   parameter PC_W        = 11,
   parameter STACK_DEPTH = 8,
   parameter STACK_W     = 12
) (
   input  wire            clk,
   input  wire            rst_n,
   input  wire            step,
   input  wire [3:0]      op,
   input  wire [10:0]     op_target,
   input  wire [7:0]      op_data,
   output reg  [10:0]     prog_addr,
   output reg  [10:0]     tbl_addr,
   input  wire [15:0]     tbl_data,
   output reg             w_load,
   output reg  [7:0]      w_data,
   input  wire            wb_cyc_i,
   input  wire            wb_stb_i,
   input  wire            wb_we_i,
   input  wire [10:0]     wb_adr_i,
   input  wire [3:0]      wb_sel_i,
   input  wire [31:0]     wb_dat_i,
   output reg  [31:0]     wb_dat_o,
   output reg             wb_ack_o
);

   // ************************************************************
   // Table read states.
   // ************************************************************
   localparam TR_IDLE  = 3'b001;
   localparam TR_FETCH = 3'b010;
   localparam TR_CAPT  = 3'b100;

   // ************************************************************
   // Helper functions.
   // ************************************************************
   function [2:0] reg_id;
      input [8:0] idx;
      begin
         case (idx)
            `PST_IDX_LOW_B0, `PST_IDX_LOW_B1,
            `PST_IDX_LOW_B2, `PST_IDX_LOW_B3:   reg_id = `PST_RID_LOW;
            `PST_IDX_LATH_B0, `PST_IDX_LATH_B1,
            `PST_IDX_LATH_B2, `PST_IDX_LATH_B3: reg_id = `PST_RID_LATH;
            `PST_IDX_VIEW:                      reg_id = `PST_RID_VIEW;
            `PST_IDX_TDATA:                     reg_id = `PST_RID_TDATA;
            `PST_IDX_PTR_LO:                    reg_id = `PST_RID_PTR_LO;
            `PST_IDX_PTR_HI:                    reg_id = `PST_RID_PTR_HI;
            default:                            reg_id = `PST_RID_NONE;
         endcase
      end
   endfunction

   // A low-byte write keeps the page while the flag is set, else takes the latch.
   function [10:0] low_load;
      input       sel_flag;
      input [2:0] latch_hi;
      input [2:0] pc_hi;
      input [7:0] low;
      begin
         if (sel_flag) begin
            low_load = {pc_hi, low};
         end else begin
            low_load = {latch_hi, low};
         end
      end
   endfunction

   // Both the call push and the plain advance need the same increment.
   function [PC_W-1:0] pc_inc;
      input [PC_W-1:0] v;
      begin
         pc_inc = v + {{(PC_W-1){1'b0}}, 1'b1};
      end
   endfunction

   // Registers are a byte wide; the upper bus lanes always read as zero.
   function [31:0] bus_byte;
      input [7:0] b;
      begin
         bus_byte = {24'h000000, b};
      end
   endfunction

   // Pointer width follows the depth; the wrap over the oldest entry needs a power-of-two depth.
   function integer ptr_bits;
      input integer depth;
      integer k;
      begin
         ptr_bits = 1;
         for (k = 2; k < depth; k = k * 2) begin
            ptr_bits = ptr_bits + 1;
         end
      end
   endfunction

   localparam STACK_PTR_W = ptr_bits(STACK_DEPTH);

   // ************************************************************
   // State.
   // ************************************************************
   reg  [PC_W-1:0]    pc;
   reg  [7:0]         counter_high_latch;
   reg                high_source_select_flag;
   reg  [7:0]         table_read_data;
   reg  [7:0]         data_pointer_low;
   reg  [7:0]         data_pointer_high;
   reg  [2:0]         tr_state;
   reg                tr_high;
   reg                tr_from_bus;
   reg                tr_bus_wait;

   reg  [PC_W-1:0]    next_pc;
   reg                stk_push;
   reg                stk_pop;
   reg  [STACK_W-1:0] stk_push_data;
   wire [STACK_W-1:0] stk_top;

   // ************************************************************
   // Bus decode.
   // ************************************************************
   wire       wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~tr_bus_wait;
   wire [2:0] rid        = reg_id(wb_adr_i[10:2]);
   wire       wr_ok      = wb_we_i & wb_sel_i[0];
   wire [7:0] wdat       = wb_dat_i[7:0];
   wire       tr_inst    = step & ((op == `PST_OP_TRL) | (op == `PST_OP_TRH));
   wire       tdata_value = (wdat == `PST_TDATA_LOW) | (wdat == `PST_TDATA_HIGH);
   wire       tdata_wr    = wr_ok & (rid == `PST_RID_TDATA) & tdata_value;
   wire       low_wr      = wr_ok & (rid == `PST_RID_LOW);

   // The decoder has priority; a bus access that collides simply waits.
   wire       wb_hold    = (low_wr & step) | (tdata_wr & ((tr_state != TR_IDLE) | tr_inst));
   wire       wb_take    = wb_req & ~wb_hold;
   wire       tr_bus     = wb_take & tdata_wr;
   wire       tr_start   = ((tr_state == TR_IDLE) & tr_inst) | tr_bus;
   wire       tr_done    = (tr_state == TR_CAPT);
   wire [7:0] tr_byte    = tr_high ? tbl_data[15:8] : tbl_data[7:0];

   // ************************************************************
   // Program counter sequencing.
   // ************************************************************
   always @* begin
      next_pc       = pc;
      stk_push      = 1'b0;
      stk_pop       = 1'b0;
      stk_push_data = {STACK_W{1'b0}};
      if (step) begin
         case (op)
            `PST_OP_GOTO: begin
               next_pc = op_target;
            end
            `PST_OP_CALL: begin
               next_pc       = op_target;
               stk_push      = 1'b1;
               stk_push_data = {1'b0, pc_inc(pc)};
            end
            `PST_OP_RETURN, `PST_OP_RETLIT: begin
               next_pc = stk_top[PC_W-1:0];
               stk_pop = 1'b1;
            end
            `PST_OP_INT: begin
               next_pc       = `PST_INT_VEC;
               stk_push      = 1'b1;
               stk_push_data = {1'b0, pc};
            end
            `PST_OP_LOWWR: begin
               next_pc = low_load(high_source_select_flag, counter_high_latch[2:0], pc[10:8], op_data);
            end
            default: begin
               next_pc = pc_inc(pc);
            end
         endcase
      end else if (wb_take & low_wr) begin
         next_pc = low_load(high_source_select_flag, counter_high_latch[2:0], pc[10:8], wdat);
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc        <= `PST_RESET_VEC;
         prog_addr <= `PST_RESET_VEC;
      end else begin
         pc        <= next_pc;
         prog_addr <= next_pc;
      end
   end

   pst_stack #(
      .DEPTH     (STACK_DEPTH),
      .WIDTH     (STACK_W),
      .PTR_W     (STACK_PTR_W)
   ) u_stack (
      .clk       (clk),
      .rst_n     (rst_n),
      .push      (stk_push),
      .pop       (stk_pop),
      .push_data (stk_push_data),
      .top       (stk_top)
   );

   // ************************************************************
   // Software registers.
   // ************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         counter_high_latch      <= `PST_BYTE_RST;
         high_source_select_flag <= 1'b0;
         data_pointer_low        <= `PST_BYTE_RST;
         data_pointer_high       <= `PST_BYTE_RST;
      end else if (wb_take & wr_ok) begin
         case (rid)
            `PST_RID_LATH: begin
               counter_high_latch <= wdat;
            end
            `PST_RID_VIEW: begin
               high_source_select_flag <= (wdat == `PST_SEL_KEY);
            end
            `PST_RID_PTR_LO: begin
               data_pointer_low <= wdat;
            end
            `PST_RID_PTR_HI: begin
               data_pointer_high <= wdat;
            end
            default: begin
               high_source_select_flag <= high_source_select_flag;
            end
         endcase
      end
   end

   // ************************************************************
   // Table read engine.
   // ************************************************************
   // The memory answers one cycle after the address, so a read takes
   // three edges; a second request meanwhile from the decoder is dropped.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tr_state        <= TR_IDLE;
         tr_high         <= 1'b0;
         tr_from_bus     <= 1'b0;
         tbl_addr        <= `PST_RESET_VEC;
         table_read_data <= `PST_BYTE_RST;
      end else begin
         case (tr_state)
            TR_IDLE: begin
               if (tr_start) begin
                  tr_state    <= TR_FETCH;
                  tbl_addr    <= {data_pointer_high[2:0], data_pointer_low};
                  tr_from_bus <= tr_bus;
                  tr_high     <= tr_bus ? (wdat == `PST_TDATA_HIGH) : (op == `PST_OP_TRH);
               end
            end
            TR_FETCH: begin
               tr_state <= TR_CAPT;
            end
            TR_CAPT: begin
               tr_state        <= TR_IDLE;
               table_read_data <= tr_byte;
            end
            default: begin
               tr_state <= TR_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Working register load.
   // ************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         w_load <= 1'b0;
         w_data <= `PST_BYTE_RST;
      end else if (tr_done) begin
         w_load <= 1'b1;
         w_data <= tr_byte;
      end else if (step & (op == `PST_OP_RETLIT)) begin
         w_load <= 1'b1;
         w_data <= op_data;
      end else begin
         w_load <= 1'b0;
      end
   end

   // ************************************************************
   // Read data select.
   // ************************************************************
   reg  [31:0]        next_wb_dat;

   always @* begin
      next_wb_dat = 32'h00000000;
      case (rid)
         `PST_RID_LOW:    next_wb_dat = bus_byte(pc[7:0]);
         `PST_RID_LATH:   next_wb_dat = bus_byte(counter_high_latch);
         `PST_RID_VIEW:   next_wb_dat = bus_byte({5'h00, pc[10:8]});
         `PST_RID_TDATA:  next_wb_dat = bus_byte(table_read_data);
         `PST_RID_PTR_LO: next_wb_dat = bus_byte(data_pointer_low);
         `PST_RID_PTR_HI: next_wb_dat = bus_byte(data_pointer_high);
         default:         next_wb_dat = 32'h00000000;
      endcase
   end

   // ************************************************************
   // Bus answer.
   // ************************************************************
   // A triggering write is answered only when the byte is in place, so
   // software that reads right after the ack always sees fresh data.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o    <= 1'b0;
         wb_dat_o    <= 32'h00000000;
         tr_bus_wait <= 1'b0;
      end else begin
         wb_ack_o <= (wb_take & ~tr_bus) | (tr_done & tr_from_bus);
         if (tr_bus) begin
            tr_bus_wait <= 1'b1;
         end else if (tr_done) begin
            tr_bus_wait <= 1'b0;
         end
         if (wb_take) begin
            wb_dat_o <= next_wb_dat;
         end
      end
   end

endmodule // pst_core

// ===== tb/pst_rom.sv
`timescale 1ns/100ps
module pst_rom (
   input  wire        clk,
   input  wire [10:0] tbl_addr,
   output reg  [15:0] tbl_data
);
   // **********************************************
   // Program memory model
   // **********************************************
   // Each word is made from its own address, so a wrong pointer shows up as a wrong byte.
   initial tbl_data = 16'h0000;
   always @(posedge clk) begin
      tbl_data <= {tbl_addr[7:0] ^ 8'h3C, 5'h19, tbl_addr[10:8]};
   end
endmodule // pst_rom

// ===== tb/pst_core_chk.sv
`timescale 1ns/100ps
module pst_core_chk (
   input wire        clk,
   input wire        rst_n,
   input wire        step,
   input wire [3:0]  op,
   input wire [10:0] op_target,
   input wire [7:0]  op_data,
   input wire [10:0] prog_addr,
   input wire [15:0] tbl_data,
   input wire        w_load,
   input wire [7:0]  w_data,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [10:0] wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o
);
   // **********************************************
   // Properties
   // **********************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire rd_ack = wb_ack_o && !wb_we_i;
   wire wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
   reset_vector_a: assert property (disable iff (1'b0) !rst_n |-> prog_addr == 11'h000 && !wb_ack_o)
      else $error("counter not cleared in reset");
   pc_advance_a: assert property (step && op == 4'h0 |=> prog_addr == $past(prog_addr) + 11'h001)
      else $error("counter did not advance");
   jump_target_a: assert property (step && (op == 4'h1 || op == 4'h2) |=> prog_addr == $past(op_target))
      else $error("jump target not loaded");
   int_vector_a: assert property (step && op == 4'h5 |=> prog_addr == 11'h004)
      else $error("interrupt vector not loaded");
   call_return_a: assert property (step && op == 4'h2 ##1 step && op == 4'h3 |=>
      prog_addr == $past(prog_addr, 2) + 11'h001) else $error("return address wrong after call");
   int_return_a: assert property (step && op == 4'h5 ##1 step && op == 4'h3 |=>
      prog_addr == $past(prog_addr, 2)) else $error("return address wrong after interrupt");
   literal_load_a: assert property (step && op == 4'h4 |=> w_load && w_data == $past(op_data))
      else $error("literal not loaded");
   table_op_a: assert property (step && (op == 4'h6 || op == 4'h7) |-> ##[2:4] w_load)
      else $error("table read gave no load");
   low_read_a: assert property (rd_ack && wb_adr_i[8:2] == 7'h02 && !$past(step) |->
      wb_dat_o == {24'h0, prog_addr[7:0]}) else $error("low byte read wrong");
   view_read_a: assert property (rd_ack && wb_adr_i[10:2] == 9'h10C && !$past(step) |->
      wb_dat_o == {29'h0, prog_addr[10:8]}) else $error("high view read wrong");
   view_write_a: assert property (wr_ack && wb_adr_i[10:2] == 9'h10C && !$past(step) && !$past(step, 2) |->
      prog_addr == $past(prog_addr, 2)) else $error("view write moved counter");
   low_write_a: assert property (wr_ack && wb_adr_i[8:2] == 7'h02 |-> prog_addr[7:0] == wb_dat_i[7:0])
      else $error("low byte write lost");
   low_op_a: assert property (step && op == 4'h8 |=> prog_addr[7:0] == $past(op_data))
      else $error("low byte step lost");
   trig_byte_a: assert property (wr_ack && wb_adr_i[10:2] == 9'h18C && wb_dat_i[7:0] == 8'h01 |->
      w_load && w_data == $past(tbl_data[7:0])) else $error("triggered read byte wrong");
   call_ret_c: cover property (step && op == 4'h2 ##1 step && op == 4'h3);
   trig_c: cover property (wr_ack && wb_adr_i[10:2] == 9'h18C);
   low_wr_c: cover property (wr_ack && wb_adr_i[8:2] == 7'h02);
endmodule // pst_core_chk

bind pst_core pst_core_chk u_chk (.clk(clk), .rst_n(rst_n), .step(step), .op(op), .op_target(op_target),
   .op_data(op_data), .prog_addr(prog_addr), .tbl_data(tbl_data), .w_load(w_load), .w_data(w_data),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// ===== tb/test_pst_core.sv
`timescale 1ns/100ps
module test_pst_core;
   reg         clk, rst_n, step, wb_cyc_i, wb_stb_i, wb_we_i;
   reg  [3:0]  op, wb_sel_i;
   reg  [10:0] op_target, wb_adr_i;
   reg  [7:0]  op_data;
   reg  [31:0] wb_dat_i, q;
   wire [10:0] prog_addr, tbl_addr;
   wire [15:0] tbl_data;
   wire        w_load, wb_ack_o;
   wire [7:0]  w_data;
   wire [31:0] wb_dat_o;
   integer     err_total, cmp_count, i;
   localparam [43:0] RA = {11'h008, 11'h028, 11'h430, 11'h630};

   always #25 clk = ~clk;

   pst_core dut (.clk(clk), .rst_n(rst_n), .step(step), .op(op), .op_target(op_target), .op_data(op_data),
      .prog_addr(prog_addr), .tbl_addr(tbl_addr), .tbl_data(tbl_data), .w_load(w_load), .w_data(w_data),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   pst_rom u_rom (.clk(clk), .tbl_addr(tbl_addr), .tbl_data(tbl_data));

   // **********************************************
   // Tasks
   // **********************************************
   task end_sim;
      begin
         $display("mismatches %0d comparisons %0d", err_total, cmp_count);
         if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask

   task chk(input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   // A hung slave ends the run here rather than stalling the bench.
   task wb(input w, input [10:0] a, input [7:0] d);
      integer n;
      begin
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= {24'h0, d};
         wb_sel_i <= 4'hF;
         n = 0;
         do begin
            @(posedge clk);
            n = n + 1;
         end while (wb_ack_o !== 1'b1 && n < 20);
         if (wb_ack_o !== 1'b1) begin
            err_total = err_total + 1;
            end_sim;
         end
         q = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         @(posedge clk);
      end
   endtask

   task stp(input [3:0] o, input [10:0] t, input [7:0] d);
      begin
         step <= 1'b1;
         op <= o;
         op_target <= t;
         op_data <= d;
         @(posedge clk);
      end
   endtask

   task idl;
      begin
         step <= 1'b0;
         @(posedge clk);
      end
   endtask

   task waitw;
      integer n;
      begin
         n = 0;
         while (w_load !== 1'b1 && n < 10) begin
            @(posedge clk);
            n = n + 1;
         end
         if (w_load !== 1'b1) begin
            err_total = err_total + 1;
            end_sim;
         end
      end
   endtask

   // **********************************************
   // Sequence
   // **********************************************
   initial begin
      clk = 1'b0; rst_n = 1'b1; step = 1'b0; op = 4'h0; op_target = 11'h000; op_data = 8'h00;
      wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 11'h000; wb_sel_i = 4'h0;
      wb_dat_i = 32'h0; err_total = 0; cmp_count = 0;
      // A clean falling edge lets the asynchronous reset act before the first clock.
      #1 rst_n = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 4; i = i + 1) begin
         wb(1'b0, RA[i*11 +: 11], 8'h00);
         chk(q, 8'h00);
      end
      wb(1'b0, 11'h7FC, 8'h00);
      chk(q, 8'h00);
      stp(4'h0, 11'h000, 8'h00); stp(4'h0, 11'h000, 8'h00); idl;
      chk(prog_addr, 11'h002);
      stp(4'h1, 11'h7FF, 8'h00); stp(4'h0, 11'h000, 8'h00); idl;
      chk(prog_addr, 11'h000);
      stp(4'h1, 11'h5A3, 8'h00); idl;
      for (i = 0; i < 4; i = i + 1) begin
         wb(1'b0, {i[1:0], 9'h008}, 8'h00);
         chk(q, 8'hA3);
      end
      wb(1'b0, 11'h430, 8'h00); chk(q, 8'h05);
      wb(1'b1, 11'h430, 8'h07); chk(prog_addr, 11'h5A3);
      wb(1'b1, 11'h228, 8'h03); wb(1'b1, 11'h408, 8'h22); chk(prog_addr, 11'h322);
      wb(1'b1, 11'h028, 8'h06); wb(1'b1, 11'h430, 8'h1C);
      wb(1'b1, 11'h208, 8'h44); chk(prog_addr, 11'h344);
      wb(1'b1, 11'h430, 8'h1D); wb(1'b1, 11'h608, 8'h55); chk(prog_addr, 11'h655);
      wb(1'b1, 11'h430, 8'h1C);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(prog_addr, 11'h000);
      wb(1'b1, 11'h028, 8'h02); wb(1'b1, 11'h008, 8'h12); chk(prog_addr, 11'h212);
      stp(4'h8, 11'h000, 8'h34); idl; chk(prog_addr, 11'h234);
      wb(1'b1, 11'h430, 8'h1C); wb(1'b1, 11'h028, 8'h05);
      wb(1'b0, 11'h628, 8'h00); chk(q, 8'h05);
      stp(4'h8, 11'h000, 8'h56); idl; chk(prog_addr, 11'h256);
      // Nine nested calls: the first return address must be lost to the wrap.
      stp(4'h1, 11'h100, 8'h00);
      for (i = 0; i < 9; i = i + 1) stp(4'h2, 11'(12'h200 + i * 16), 8'h00);
      for (i = 1; i <= 8; i = i + 1) begin
         stp((i == 8) ? 4'h4 : 4'h3, 11'h000, 8'h5A); idl;
         chk(prog_addr, 11'(12'h201 + (8 - i) * 16));
      end
      chk(w_data, 8'h5A);
      stp(4'h1, 11'h3F0, 8'h00); stp(4'h5, 11'h000, 8'h00); stp(4'h3, 11'h000, 8'h00); idl;
      chk(prog_addr, 11'h3F0);
      wb(1'b1, 11'h614, 8'hC7); wb(1'b1, 11'h618, 8'h02);
      stp(4'h6, 11'h000, 8'h00); idl; waitw;
      chk(w_data, 8'hCA);
      chk(tbl_addr, 11'h2C7);
      wb(1'b0, 11'h618, 8'h00); chk(q, 8'h02);
      stp(4'h7, 11'h000, 8'h00); idl; waitw;
      chk(w_data, 8'hFB);
      wb(1'b1, 11'h630, 8'h01); wb(1'b0, 11'h630, 8'h00); chk(q, 8'hCA);
      wb(1'b1, 11'h630, 8'h02); wb(1'b0, 11'h630, 8'h00); chk(q, 8'hFB);
      end_sim;
   end
endmodule // test_pst_core
